/* File: rtl/smp_device.sv */
// Behaviour
// - sample input bit on rising clock
// - shift output bit on falling clock
// - programmer clock phases above two or three cycles
// - enable instruction first, else program/erase rejected
// - enable is ac 53; echo 53 in byte three
// - programmer sends four bytes; resync via reset
// - programmer holds reset, clock low at power-up; rst_n is driven as ~session_i, so reset is held only while session_i is high
// - programmer waits 20 ms before enabling; no wait if session_i is already high when arst_n_i releases
// - chip erase sets flash and eeprom to ff
// - eeprom write auto-erases target location
// - page buffer loaded by byte, low first
// - write-page commits buffer to selected page
// - programmer waits 4.5 ms after page write
// - eeprom byte write, programmer waits 3.6 ms
// - busy flash page reads ff until done
// - busy eeprom byte reads ff until done
// - reads shift stored byte out in byte four
// - eeprom page buffer load and page write
// - lock read 58, write e0 group, zero programmed
// - fuse write stores data bits directly
// - reset high leaves programming mode
// - busy poll returns flag in last bit
`timescale 1ns/1ps
`default_nettype none
`include "smp_defines.svh"
module smp_device
    import smp_pkg::*;
#(
    parameter int FL_AW  = 13,
    parameter int EE_AW  = 9,
    parameter int PG_AW  = 6,
    parameter int EEP_AW = 2,
    parameter int T_FLASH = `SMP_T_FLASH_US * `SMP_CLK_MHZ,
    parameter int T_EE    = `SMP_T_EE_US * `SMP_CLK_MHZ,
    parameter int T_ERASE = `SMP_T_ERASE_US * `SMP_CLK_MHZ
) (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       arst_n_i,
    // link
    smp_if.device           lnk,
    // user side
    output logic            prog_mode_o,
    output logic            programming_busy_flag_o,
    output logic [7:0]      lock_bits_o,
    output logic [7:0]      fuse_bits_o
);
    // ========================================
    // pin synchronisers
    logic [1:0] sck_s_ff, mosi_s_ff, rst_s_ff;
    logic       sck_d_ff;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sck_s_ff  <= 2'h0;
            mosi_s_ff <= 2'h0;
            rst_s_ff  <= 2'h3;
            sck_d_ff  <= 1'b0;
        end else begin
            sck_s_ff  <= {sck_s_ff[0], lnk.sck};
            mosi_s_ff <= {mosi_s_ff[0], lnk.mosi};
            rst_s_ff  <= {rst_s_ff[0], lnk.rst_n};
            sck_d_ff  <= sck_s_ff[1];
        end
    end
    logic sck_rise, sck_fall, in_rst;
    assign sck_rise = sck_s_ff[1] & ~sck_d_ff;
    assign sck_fall = ~sck_s_ff[1] & sck_d_ff;
    assign in_rst   = ~rst_s_ff[1];

    // ========================================
    // frame shifter
    logic [4:0]  bit_cnt_ff;
    logic [31:0] sh_in_ff;
    logic [7:0]  sh_out_ff;
    logic        miso_ff;
    logic [31:0] frame;
    logic        frame_done, byte_done;
    assign frame      = {sh_in_ff[30:0], mosi_s_ff[1]};
    assign frame_done = sck_rise & (bit_cnt_ff == 5'h1f);
    assign byte_done  = sck_rise & (bit_cnt_ff[2:0] == 3'h7);
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bit_cnt_ff <= 5'h0;
            sh_in_ff   <= 32'h0;
        end else if (!in_rst) begin
            bit_cnt_ff <= 5'h0;
        end else if (sck_rise) begin
            sh_in_ff   <= frame;
            bit_cnt_ff <= bit_cnt_ff + 5'h1;
        end
    end

    // ========================================
    // memories and state
    logic [7:0]  flash_ff [2**(FL_AW+1)];
    logic [7:0]  ee_ff    [2**EE_AW];
    logic [7:0]  pbuf_ff  [2**(PG_AW+1)];
    logic [7:0]  ebuf_ff  [2**EEP_AW];
    logic        en_ff;
    smp_nvm_st_t st_ff;
    logic [31:0] tmr_ff;
    logic        busy_fl_ff, busy_ee_ff, ee_pg_ff;
    logic [FL_AW-PG_AW-1:0] bpage_ff;
    logic [EE_AW-1:0]       bee_ff;
    logic [7:0]  resp;
    logic [7:0]  b1, b2, b3, b4;
    assign {b1, b2, b3, b4} = frame;
    logic [FL_AW-1:0] rd_wa;
    assign rd_wa = FL_AW'({b2, b3});
    logic [EE_AW-1:0] ee_a;
    assign ee_a = EE_AW'({b2, b3});
    logic prog_op;
    assign prog_op = frame_done & en_ff & (st_ff == SMP_IDLE);
    // eeprom page base
    logic [EE_AW-1:0] eep_base;
    assign eep_base = {ee_a[EE_AW-1:EEP_AW], {EEP_AW{1'b0}}};

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            en_ff <= 1'b0;
        end else if (!in_rst) begin
            en_ff <= 1'b0;
        end else if (frame_done && b1 == `SMP_OP_PROG && b2 == `SMP_B2_ENABLE) begin
            en_ff <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff       <= SMP_IDLE;
            tmr_ff      <= 32'h0;
            busy_fl_ff  <= 1'b0;
            busy_ee_ff  <= 1'b0;
            ee_pg_ff    <= 1'b0;
            bpage_ff    <= '0;
            bee_ff      <= '0;
            lock_bits_o <= 8'hff;
            fuse_bits_o <= 8'hff;
        end else if (st_ff == SMP_BUSY) begin
            if (tmr_ff == 32'h0) begin
                st_ff      <= SMP_IDLE;
                busy_fl_ff <= 1'b0;
                busy_ee_ff <= 1'b0;
            end else begin
                tmr_ff <= tmr_ff - 32'h1;
            end
        end else if (prog_op) begin
            if (b1 == `SMP_OP_PROG && b2[7:5] == `SMP_B2_ERASE_HI) begin
                st_ff       <= SMP_BUSY;
                tmr_ff      <= T_ERASE;
                lock_bits_o <= 8'hff;
            end else if (b1 == `SMP_OP_PROG && b2[7:5] == `SMP_B2_LOCK_HI) begin
                lock_bits_o <= {2'h3, b4[5:0]};
            end else if (b1 == `SMP_OP_PROG && b2 == `SMP_B2_FUSE) begin
                fuse_bits_o <= b4;
            end else if (b1 == `SMP_OP_WR_PM) begin
                st_ff      <= SMP_BUSY;
                tmr_ff     <= T_FLASH;
                busy_fl_ff <= 1'b1;
                bpage_ff   <= rd_wa[FL_AW-1:PG_AW];
            end else if (b1 == `SMP_OP_WR_EE) begin
                st_ff      <= SMP_BUSY;
                tmr_ff     <= T_EE;
                busy_ee_ff <= 1'b1;
                bee_ff     <= ee_a;
                ee_pg_ff   <= 1'b0;
            end else if (b1 == `SMP_OP_WR_EEP) begin
                st_ff      <= SMP_BUSY;
                tmr_ff     <= T_EE;
                busy_ee_ff <= 1'b1;
                bee_ff     <= eep_base;
                ee_pg_ff   <= 1'b1; // page write hides its whole page, byte write one byte
            end
        end
    end

    // memory writes happen at the commit; readers of the busy page or byte see ff while busy
    always_ff @(posedge sys_clk_i) begin
        if (prog_op && b1 == `SMP_OP_PROG && b2[7:5] == `SMP_B2_ERASE_HI) begin
            for (int i = 0; i < 2**(FL_AW+1); i++) flash_ff[i] <= `SMP_ERASED;
            for (int i = 0; i < 2**EE_AW; i++) ee_ff[i] <= `SMP_ERASED;
        end else if (prog_op && b1 == `SMP_OP_WR_PM) begin
            for (int i = 0; i < 2**(PG_AW+1); i++)
                flash_ff[{rd_wa[FL_AW-1:PG_AW], (PG_AW+1)'(i)}] <= pbuf_ff[i];
        end else if (prog_op && b1 == `SMP_OP_WR_EE) begin
            ee_ff[ee_a] <= b4;
        end else if (prog_op && b1 == `SMP_OP_WR_EEP) begin
            for (int i = 0; i < 2**EEP_AW; i++)
                ee_ff[eep_base + EE_AW'(i)] <= ebuf_ff[i];
        end
        if (frame_done && en_ff && {b1[7:4], b1[2:0]} == 7'h20 && b1 != `SMP_OP_WR_PM)
            pbuf_ff[{b3[PG_AW-1:0], b1[`SMP_OP_H_BIT]}] <= b4;
        if (frame_done && en_ff && b1 == `SMP_OP_LD_EEP)
            ebuf_ff[b3[7:8-EEP_AW]] <= b4;
    end

    // ========================================
    // response byte, picked at end of byte three
    // only three bytes are in yet, so decode from the low 24 bits of the frame
    logic [7:0]       q1, q2, q3;
    logic [FL_AW-1:0] q_wa;
    logic [EE_AW-1:0] q_ea;
    assign {q1, q2, q3} = frame[23:0];
    assign q_wa = FL_AW'({q2, q3});
    assign q_ea = EE_AW'({q2, q3});
    always_comb begin
        resp = 8'h00;
        unique case (q1)
            `SMP_OP_RD_EE: resp = (busy_ee_ff && bee_ff[EE_AW-1:EEP_AW] == q_ea[EE_AW-1:EEP_AW]
                                  && (bee_ff == q_ea || ee_pg_ff)) ?
                                  `SMP_ERASED : ee_ff[q_ea];
            `SMP_OP_RD_LOCK: resp = lock_bits_o;
            `SMP_OP_RD_FUSE: resp = fuse_bits_o;
            `SMP_OP_POLL: resp = {7'h0, programming_busy_flag_o};
            default: begin
                if ({q1[7:4], q1[2:0]} == 7'h10)
                    resp = (busy_fl_ff && bpage_ff == q_wa[FL_AW-1:PG_AW]) ? `SMP_ERASED
                           : flash_ff[{q_wa, q1[`SMP_OP_H_BIT]}];
            end
        endcase
    end

    // ========================================
    // output shifter, changes on falling clock
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sh_out_ff <= 8'h0;
            miso_ff   <= 1'b0;
        end else if (!in_rst) begin
            sh_out_ff <= 8'h0;
            miso_ff   <= 1'b0;
        end else begin
            // rising and falling edges never meet in one cycle
            if (byte_done && bit_cnt_ff[4:3] == 2'h0)
                sh_out_ff <= 8'h0;
            else if (byte_done && bit_cnt_ff[4:3] == 2'h1)
                sh_out_ff <= frame[7:0];
            else if (byte_done && bit_cnt_ff[4:3] == 2'h2)
                sh_out_ff <= resp;
            if (sck_fall) begin
                miso_ff   <= sh_out_ff[7];
                sh_out_ff <= {sh_out_ff[6:0], 1'b0};
            end
        end
    end
    assign lnk.miso      = miso_ff;
    assign lnk.miso_oe_n = ~in_rst;
    assign prog_mode_o   = en_ff;
    assign programming_busy_flag_o = (st_ff == SMP_BUSY);
endmodule : smp_device
`default_nettype wire

/* File: inc/smp_defines.svh */
`ifndef SMP_DEFINES_SVH
`define SMP_DEFINES_SVH
// opcodes, byte 1
`define SMP_OP_PROG      8'hac
`define SMP_OP_RD_PM     8'h20
`define SMP_OP_LD_PM     8'h40
`define SMP_OP_WR_PM     8'h4c
`define SMP_OP_RD_EE     8'ha0
`define SMP_OP_WR_EE     8'hc0
`define SMP_OP_LD_EEP    8'hc1
`define SMP_OP_WR_EEP    8'hc2
`define SMP_OP_RD_LOCK   8'h58
`define SMP_OP_RD_FUSE   8'h50
`define SMP_OP_POLL      8'hf0
// byte 2 of the ac group
`define SMP_B2_ENABLE    8'h53
`define SMP_B2_FUSE      8'ha0
`define SMP_B2_ERASE_HI  3'h4
`define SMP_B2_LOCK_HI   3'h7
`define SMP_OP_H_BIT     3
`define SMP_ERASED       8'hff
// timing
`define SMP_CLK_MHZ      200
`define SMP_T_FLASH_US   4500
`define SMP_T_EE_US      3600
`define SMP_T_ERASE_US   9000
`define SMP_T_PWRUP_US   20000
`define SMP_HALF_SCK     5
`endif

/* File: inc/smp_pkg.sv */
`default_nettype none
package smp_pkg;
    typedef enum logic [1:0] {
        SMP_IDLE = 2'b00,
        SMP_BUSY = 2'b01
    } smp_nvm_st_t;
endpackage : smp_pkg
`default_nettype wire

/* File: inc/smp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface smp_if;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe_n;
    logic rst_n;
    modport device (input sck, input mosi, input rst_n, output miso, output miso_oe_n);
    modport prog (output sck, output mosi, output rst_n, input miso, input miso_oe_n);
endinterface : smp_if
`default_nettype wire

/* File: rtl/smp_prog.sv */
`timescale 1ns/1ps
`default_nettype none
`include "smp_defines.svh"
module smp_prog
    import smp_pkg::*;
#(
    parameter int T_PWRUP = `SMP_T_PWRUP_US * `SMP_CLK_MHZ,
    parameter int HALF    = `SMP_HALF_SCK
) (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        arst_n_i,
    // user side: one 32-bit instruction, answer is last byte
    input  wire logic        session_i,
    input  wire logic        cmd_valid_i,
    output logic             cmd_ready_o,
    input  wire logic [31:0] cmd_data_i,
    output logic             rsp_valid_o,
    input  wire logic        rsp_ready_i,
    output logic [7:0]       rsp_data_o,
    output logic             echo_ok_o,
    // link
    smp_if.prog              lnk
);
    // ========================================
    // two-entry buffer on the answer path
    logic [7:0] fq_ff [2];
    logic [1:0] cnt_ff;
    logic       wp_ff, rp_ff, push;
    assign rsp_valid_o = cnt_ff != 2'h0;
    assign rsp_data_o  = fq_ff[rp_ff];
    // ========================================
    // sync of returning data
    logic [1:0] miso_s_ff;
    logic [31:0] wait_ff;
    logic [3:0]  div_ff;
    logic [5:0]  bit_ff;
    logic [31:0] tx_ff;
    logic [31:0] rx_ff;
    logic        busy_ff, sck_ff;
    assign cmd_ready_o = !busy_ff && wait_ff == 32'h0 && session_i && cnt_ff != 2'h2;
    assign push = busy_ff && div_ff == 4'h0 && sck_ff && bit_ff == 6'h1f;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            miso_s_ff <= 2'h0;
            wait_ff   <= 32'h0;
            div_ff    <= 4'h0;
            bit_ff    <= 6'h0;
            tx_ff     <= 32'h0;
            rx_ff     <= 32'h0;
            busy_ff   <= 1'b0;
            sck_ff    <= 1'b0;
            echo_ok_o <= 1'b0;
        end else begin
            miso_s_ff <= {miso_s_ff[0], lnk.miso};
            if (!session_i) begin
                wait_ff <= T_PWRUP;
                busy_ff <= 1'b0;
                sck_ff  <= 1'b0;
            end else if (wait_ff != 32'h0) begin
                wait_ff <= wait_ff - 32'h1;
            end else if (cmd_valid_i && cmd_ready_o) begin
                tx_ff   <= cmd_data_i;
                busy_ff <= 1'b1;
                bit_ff  <= 6'h0;
                div_ff  <= 4'(HALF);
            end else if (busy_ff) begin
                if (div_ff != 4'h0) begin
                    div_ff <= div_ff - 4'h1;
                end else begin
                    div_ff <= 4'(HALF);
                    sck_ff <= ~sck_ff;
                    if (!sck_ff) begin
                        rx_ff <= {rx_ff[30:0], miso_s_ff[1]};
                    end else begin
                        tx_ff  <= {tx_ff[30:0], 1'b0};
                        bit_ff <= bit_ff + 6'h1;
                        if (bit_ff == 6'h17)
                            echo_ok_o <= rx_ff[7:0] == `SMP_B2_ENABLE;
                        if (bit_ff == 6'h1f)
                            busy_ff <= 1'b0;
                    end
                end
            end
        end
    end
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_ff <= 2'h0;
            wp_ff  <= 1'b0;
            rp_ff  <= 1'b0;
        end else begin
            if (push)
                wp_ff <= ~wp_ff;
            if (rsp_valid_o && rsp_ready_i)
                rp_ff <= ~rp_ff;
            cnt_ff <= cnt_ff + 2'(push) - 2'(rsp_valid_o && rsp_ready_i);
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (push)
            fq_ff[wp_ff] <= rx_ff[7:0];
    end
    assign lnk.sck   = sck_ff;
    assign lnk.mosi  = tx_ff[31];
    assign lnk.rst_n = ~session_i;
endmodule : smp_prog
`default_nettype wire

/* File: verif/smp_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module smp_monitor (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // link wires
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n,
    input wire logic rst_n
);
    // ==========
    // frame capture
    logic        sck_ff;
    logic [4:0]  bit_ff;
    logic [31:0] in_ff;
    logic [31:0] out_ff;
    logic        done_ff;
    logic [5:0]  idle_ff;
    logic        rise;
    assign rise = sck & ~sck_ff;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) sck_ff <= 1'h0;
        else sck_ff <= sck;
    end
    // both wires are taken at the rising edge, as both ends must
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in_ff  <= 32'h0;
            out_ff <= 32'h0;
        end else if (rise) begin
            in_ff  <= {in_ff[30:0], mosi};
            out_ff <= {out_ff[30:0], miso};
        end
    end
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) bit_ff <= 5'h0;
        else if (rst_n) bit_ff <= 5'h0;
        else if (rise) bit_ff <= bit_ff + 5'h1;
    end
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) done_ff <= 1'h0;
        else done_ff <= rise && !rst_n && bit_ff == 5'h1f;
    end
    // saturates, so a long gap cannot wrap into a false check
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) idle_ff <= 6'h0;
        else if (sck != sck_ff) idle_ff <= 6'h0;
        else if (idle_ff != 6'h3f) idle_ff <= idle_ff + 6'h1;
    end
    // ==========
    // checks
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_enable_frame;
        done_ff && in_ff[31:16] == 16'hac53;
    endsequence
    AST_ECHO: assert property (s_enable_frame |-> out_ff[15:8] == 8'h53)
        else $error("enable echo missing in third byte");
    AST_SCK_HIGH: assert property ($rose(sck) |-> sck [*3])
        else $error("serial clock high phase too short");
    AST_SCK_LOW: assert property ($fell(sck) |-> !sck [*3])
        else $error("serial clock low phase too short");
    AST_IDLE_CLK: assert property (rst_n [*2] |-> !sck)
        else $error("serial clock moves outside a session");
    AST_FRAME_WHOLE: assert property (idle_ff == 6'h20 |-> bit_ff == 5'h0)
        else $error("clock stopped inside a frame");
    AST_MOSI_HOLD: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("data in moved while clock high");
    AST_MISO_HOLD: assert property (sck && $past(sck) && !miso_oe_n
        && !$past(miso_oe_n) |-> $stable(miso))
        else $error("data out moved while clock high");
    AST_RELEASE: assert property (rst_n [*4] |-> miso_oe_n)
        else $error("data out driven after session end");
endmodule : smp_monitor
`default_nettype wire

/* File: verif/test_serial_memory_programming_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "smp_defines.svh"
module test_serial_memory_programming_port;
    // ==========
    // bench signals
    logic        sys_clk, arst_n, session, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
    logic        echo_ok, prog_mode, busy;
    logic [31:0] cmd_data;
    logic [7:0]  rsp_data, lock_bits, fuse_bits, r, d, e;
    int          a, wa, n, num_errors, checked;
    smp_if lnk_if ();
    // busy times stay longer than one frame so reads can land inside them
    smp_device #(.T_FLASH(1200), .T_EE(1000), .T_ERASE(1500)) smp_device_inst (
        .sys_clk_i(sys_clk), .arst_n_i(arst_n), .lnk(lnk_if.device),
        .prog_mode_o(prog_mode), .programming_busy_flag_o(busy),
        .lock_bits_o(lock_bits), .fuse_bits_o(fuse_bits));
    smp_prog #(.T_PWRUP(50)) smp_prog_inst (
        .sys_clk_i(sys_clk), .arst_n_i(arst_n), .session_i(session),
        .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_data_i(cmd_data),
        .rsp_valid_o(rsp_valid), .rsp_ready_i(rsp_ready), .rsp_data_o(rsp_data),
        .echo_ok_o(echo_ok), .lnk(lnk_if.prog));
    smp_monitor smp_monitor_inst (
        .sys_clk_i(sys_clk), .arst_n_i(arst_n), .sck(lnk_if.sck), .mosi(lnk_if.mosi),
        .miso(lnk_if.miso), .miso_oe_n(lnk_if.miso_oe_n), .rst_n(lnk_if.rst_n));
    // ==========
    // helpers
    function automatic logic [31:0] ee_cmd(logic [7:0] op, int ad, logic [7:0] v);
        return {op, 7'h0, ad[8], ad[7:0], v};
    endfunction : ee_cmd
    function automatic logic [31:0] fl_cmd(logic [7:0] op, int w, logic [7:0] v);
        return {op, 3'h0, w[12:8], w[7:0], v};
    endfunction : fl_cmd
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task send(input logic [31:0] c);
        @(negedge sys_clk);
        cmd_data  = c;
        cmd_valid = 1'h1;
        for (n = 0; n < 30000 && cmd_ready !== 1'h1; n++) @(negedge sys_clk);
        @(negedge sys_clk);
        cmd_valid = 1'h0;
    endtask : send
    task recv(output logic [7:0] v);
        @(negedge sys_clk);
        for (n = 0; n < 3000 && rsp_valid !== 1'h1; n++) @(negedge sys_clk);
        v = rsp_data;
        rsp_ready = 1'h1;
        @(negedge sys_clk);
        rsp_ready = 1'h0;
    endtask : recv
    task xfer(input logic [31:0] c, output logic [7:0] v);
        send(c);
        recv(v);
    endtask : xfer
    task wait_idle;
        r = 8'h1;
        for (int k = 0; k < 20 && r[0] !== 1'h0; k++) xfer({`SMP_OP_POLL, 24'h0}, r);
        chk("idle", {6'h0, busy, r[0]}, 8'h0);
    endtask : wait_idle
    task end_of_test;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    // ==========
    // clock and watchdog
    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (90000) @(posedge sys_clk);
        num_errors++;
        $display("ERROR watchdog expected finish seen timeout");
        end_of_test();
    end
    // ==========
    // tests
    initial begin
        {arst_n, session, cmd_valid, rsp_ready} = 4'h0;
        cmd_data   = 32'h0;
        num_errors = 0;
        checked    = 0;
        void'($urandom(4501));
        repeat (16) @(negedge sys_clk);
        arst_n  = 1'h1;
        session = 1'h1;
        xfer({`SMP_OP_PROG, `SMP_B2_ENABLE, 16'h0}, r);
        chk("echo_ok", {7'h0, echo_ok}, 8'h1);
        chk("prog_mode", {7'h0, prog_mode}, 8'h1);
        xfer({`SMP_OP_PROG, `SMP_B2_ERASE_HI, 21'h0}, r);
        wait_idle();
        xfer(ee_cmd(`SMP_OP_RD_EE, $urandom_range(511), 8'h0), r);
        chk("erased", r, 8'hff);
        // byte writes: top address with 00 then ff is the corner
        for (int k = 0; k < 3; k++) begin
            a = (k == 0) ? 511 : $urandom_range(510);
            d = (k == 0) ? 8'h0 : 8'($urandom);
            xfer(ee_cmd(`SMP_OP_WR_EE, a, d), r);
            xfer(ee_cmd(`SMP_OP_RD_EE, a, 8'h0), r);
            chk("ee_busy_read", r, 8'hff);
            xfer({`SMP_OP_POLL, 24'h0}, r);
            chk("poll_busy", {6'h0, busy, r[0]}, 8'h3);
            wait_idle();
            xfer(ee_cmd(`SMP_OP_WR_EE, a, ~d), r);
            wait_idle();
            xfer(ee_cmd(`SMP_OP_RD_EE, a, 8'h0), r);
            chk("ee_rewrite", r, ~d);
        end
        // flash page: first and last word, low byte before high
        wa = $urandom_range(127) * 64;
        d  = 8'($urandom);
        for (int k = 0; k < 4; k++)
            xfer(fl_cmd(`SMP_OP_LD_PM | {4'h0, k[0], 3'h0}, wa + (k[1] ? 63 : 0),
                 d + 8'(k)), r);
        xfer(fl_cmd(`SMP_OP_WR_PM, wa, 8'h0), r);
        xfer(fl_cmd(`SMP_OP_RD_PM, wa + 63, 8'h0), r);
        chk("flash_busy_read", r, 8'hff);
        wait_idle();
        for (int k = 0; k < 4; k++) begin
            xfer(fl_cmd(`SMP_OP_RD_PM | {4'h0, k[0], 3'h0}, wa + (k[1] ? 63 : 0), 8'h0), r);
            chk("flash_word", r, d + 8'(k));
        end
        // eeprom page of four bytes
        a = $urandom_range(127) * 4;
        for (int k = 0; k < 4; k++) xfer({`SMP_OP_LD_EEP, 8'h0, 2'(k), 6'h0, d ^ 8'(k)}, r);
        xfer(ee_cmd(`SMP_OP_WR_EEP, a, 8'h0), r);
        wait_idle();
        for (int k = 0; k < 4; k++) begin
            xfer(ee_cmd(`SMP_OP_RD_EE, a + k, 8'h0), r);
            chk("ee_page", r, d ^ 8'(k));
        end
        // stalled reader: two answers fill the buffer, nothing more is taken
        send(ee_cmd(`SMP_OP_RD_EE, a + 1, 8'h0));
        send(ee_cmd(`SMP_OP_RD_EE, a + 2, 8'h0));
        n = 0;
        repeat (1000) begin
            @(negedge sys_clk);
            n += (cmd_ready !== 1'h0);
        end
        chk("full_refused", 8'(n), 8'h0);
        recv(r);
        chk("first_out", r, d ^ 8'h1);
        recv(r);
        chk("second_out", r, d ^ 8'h2);
        chk("drained", {7'h0, rsp_valid}, 8'h0);
        // lock and fuse bits
        e = 8'($urandom);
        xfer({`SMP_OP_PROG, `SMP_B2_LOCK_HI, 13'h0, 2'h3, e[5:0]}, r);
        wait_idle();
        xfer({`SMP_OP_RD_LOCK, 24'h0}, r);
        chk("lock_read", {2'h0, r[5:0]}, {2'h0, e[5:0]});
        chk("lock_bits", lock_bits, {2'h3, e[5:0]});
        xfer({`SMP_OP_PROG, `SMP_B2_FUSE, 8'h0, ~e}, r);
        wait_idle();
        xfer({`SMP_OP_RD_FUSE, 24'h0}, r);
        chk("fuse_read", r, ~e);
        chk("fuse_bits", fuse_bits, ~e);
        // second session: write and erase before enable must be dropped
        session = 1'h0;
        repeat (20) @(negedge sys_clk);
        chk("left_prog", {7'h0, prog_mode}, 8'h0);
        session = 1'h1;
        xfer(ee_cmd(`SMP_OP_WR_EE, a, ~d), r);
        xfer({`SMP_OP_PROG, `SMP_B2_ERASE_HI, 21'h0}, r);
        xfer({`SMP_OP_PROG, `SMP_B2_ENABLE, 16'h0}, r);
        chk("echo_ok2", {7'h0, echo_ok}, 8'h1);
        xfer(ee_cmd(`SMP_OP_RD_EE, a, 8'h0), r);
        chk("kept", r, d);
        end_of_test();
    end
endmodule : test_serial_memory_programming_port
`default_nettype wire
